// ==== hw/srp_pin_sync.sv ====
// Purpose: bring serial pins into the system clock and find clock edges
// Assumes: pins are asynchronous to clk
// Notes:   edge detection reads only second and third stages
`timescale 1ns/10ps
module srp_pin_sync (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	// raw pins
	input  wire logic                  sclk,
	input  wire logic                  frame_enable_n,
	input  wire logic                  sdio_in,
	// synchronised view
	output srp_pkg::srp_link_type      link
);
	import srp_pkg::*;

	logic [2:0] meta;
	logic [2:0] stable;
	logic       sclk_prev;
	logic [2:0] next_meta;
	logic [2:0] next_stable;
	logic       next_sclk_prev;

	// two stages per pin, plus previous clock level
	always_comb begin
		next_meta      = {sclk, frame_enable_n, sdio_in};
		next_stable    = meta;
		next_sclk_prev = stable[2];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta      <= 3'h2;
			stable    <= 3'h2;
			sclk_prev <= 1'b0;
		end else if (ce) begin
			meta      <= next_meta;
			stable    <= next_stable;
			sclk_prev <= next_sclk_prev;
		end
	end

	// edges of the host clock
	assign link = '{sclk_rise: stable[2] & ~sclk_prev, sclk_fall: ~stable[2] & sclk_prev,
		frame_n: stable[1], data: stable[0]};

endmodule

// ==== hw/srp_pkg.sv ====
// Purpose: shared constants and types of the serial register port
// Assumes: 25 MHz system clock, host serial clock far slower
// Notes:   register map holds 32 byte-wide configuration slots
package srp_pkg;

	// register map geometry
	localparam int          SRP_ADDR_W       = 5;
	localparam int          SRP_NUM_REGS     = 32;
	localparam logic [7:0]  SRP_REG_RESET    = 8'h00;
	// reserved slot that reads as zero and ignores writes
	localparam logic [4:0]  SRP_RSVD_1E_ADDR = 5'h1E;
	localparam logic [7:0]  SRP_RSVD_1E_VAL  = 8'h00;
	// mode register holding the four-wire select bit
	localparam logic [4:0]  SRP_MODE_ADDR    = 5'h05;
	localparam int          SRP_FOUR_WIRE_B  = 6;

	// instruction byte fields
	localparam int          SRP_RW_B         = 7;
	localparam int          SRP_CNT_HI       = 6;
	localparam int          SRP_CNT_LO       = 5;
	localparam int          SRP_ADDR_HI      = 4;
	localparam logic [2:0]  SRP_LAST_BIT     = 3'h7;
	localparam logic [2:0]  SRP_BIT_ZERO     = 3'h0;
	localparam logic [2:0]  SRP_BIT_ONE      = 3'h1;
	localparam logic [1:0]  SRP_CNT_ZERO     = 2'h0;
	localparam logic [1:0]  SRP_CNT_ONE      = 2'h1;
	localparam logic [4:0]  SRP_ADDR_ONE     = 5'h01;

	// link timing
	localparam int          SRP_CLK_MHZ      = 25;
	localparam int          SRP_SCLK_NS      = 320;
	localparam int          SRP_SCLK_CYC     = (SRP_SCLK_NS * SRP_CLK_MHZ) / 1000;

	// port sequencer states
	typedef enum logic [3:0] {
		SRP_WAIT  = 4'h1,
		SRP_INSTR = 4'h2,
		SRP_DATA  = 4'h4,
		SRP_DONE  = 4'h8
	} srp_state_type;

	// pin drive bundle toward the pads
	typedef struct packed {
		logic sdio_out;
		logic sdio_oe_n;
		logic ser_data_out;
		logic sdo_oe_n;
	} srp_pins_type;

	// synchronised link view
	typedef struct packed {
		logic sclk_rise;
		logic sclk_fall;
		logic frame_n;
		logic data;
	} srp_link_type;

	typedef logic [SRP_NUM_REGS-1:0][7:0] srp_regs_type;

endpackage

// ==== hw/srp_port.sv ====
// Purpose: serial slave port giving the host access to all config registers but the reserved slot 1E
// Assumes: host serial clock at most clk/8, pins two-way via oe_n
// Notes:   output enables are low while this block drives the pin
`timescale 1ns/10ps
module srp_port (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	// serial pins
	input  wire logic                  sclk,
	input  wire logic                  frame_enable_n,
	input  wire logic                  sdio_in,
	output logic                       sdio_out,
	output logic                       sdio_oe_n,
	output logic                       ser_data_out,
	output logic                       sdo_oe_n,
	// register contents toward the converter
	output srp_pkg::srp_regs_type      cfg_regs,
	output logic                       four_wire_select
);
	import srp_pkg::*;

	srp_link_type  link;
	srp_state_type state, next_state;
	srp_regs_type  regs, next_regs;
	srp_pins_type  pins, next_pins;
	logic [7:0]    shift, next_shift;
	logic [7:0]    tx, next_tx;
	logic [2:0]    bit_cnt, next_bit_cnt;
	logic [1:0]    left, next_left;
	logic [4:0]    addr, next_addr;
	logic          rw, next_rw;
	logic [7:0]    shifted;

	// read view of one slot, reserved slot reads fixed
	function automatic logic [7:0] reg_read(srp_regs_type r, logic [4:0] a);
		if (a == SRP_RSVD_1E_ADDR) begin
			return SRP_RSVD_1E_VAL;
		end else begin
			return r[a];
		end
	endfunction

	srp_pin_sync u_sync (
		.clk            (clk),
		.rst            (rst),
		.ce             (ce),
		.sclk           (sclk),
		.frame_enable_n (frame_enable_n),
		.sdio_in        (sdio_in),
		.link           (link)
	);

	assign shifted = {shift[6:0], link.data}; // msb first

	// sequencer, register file and pin drive next values
	always_comb begin
		next_state   = state;
		next_regs    = regs;
		next_pins    = pins;
		next_shift   = shift;
		next_tx      = tx;
		next_bit_cnt = bit_cnt;
		next_left    = left;
		next_addr    = addr;
		next_rw      = rw;
		if (link.frame_n) begin
			// frame over or aborted: drop partial byte, release pins
			next_state   = SRP_WAIT;
			next_bit_cnt = SRP_BIT_ZERO;
			next_shift   = 8'h00;
			next_pins    = '{sdio_out: 1'b0, sdio_oe_n: 1'b1,
				ser_data_out: 1'b0, sdo_oe_n: 1'b1};
		end else begin
			case (state)
				SRP_WAIT: begin
					next_state = SRP_INSTR; // first byte is instruction
				end
				SRP_INSTR: begin
					if (link.sclk_rise) begin
						next_shift   = shifted; // sample on rise
						next_bit_cnt = bit_cnt + SRP_BIT_ONE;
						if (bit_cnt == SRP_LAST_BIT) begin
							// decode direction, count, start address
							next_rw    = shifted[SRP_RW_B];
							next_left  = shifted[SRP_CNT_HI:SRP_CNT_LO];
							next_addr  = shifted[SRP_ADDR_HI:0];
							next_tx    = reg_read(regs, shifted[SRP_ADDR_HI:0]);
							next_state = SRP_DATA;
						end
					end
				end
				SRP_DATA: begin
					if (link.sclk_rise) begin
						next_shift   = shifted;
						next_bit_cnt = bit_cnt + SRP_BIT_ONE;
						if (bit_cnt == SRP_LAST_BIT) begin
							if (!rw && addr != SRP_RSVD_1E_ADDR) begin
								next_regs[addr] = shifted; // write access
							end
							if (left == SRP_CNT_ZERO) begin
								next_state = SRP_DONE;
							end else begin
								// next byte goes one register lower
								next_left = left - SRP_CNT_ONE;
								next_addr = addr - SRP_ADDR_ONE;
								next_tx   = reg_read(regs, addr - SRP_ADDR_ONE);
							end
						end
					end else if (link.sclk_fall && rw) begin
						// launch on fall, pin chosen by mode
						next_tx = {tx[6:0], 1'b0};
						next_pins.sdio_out     = tx[7];
						next_pins.ser_data_out = tx[7];
						next_pins.sdio_oe_n    = four_wire_select;
						next_pins.sdo_oe_n     = ~four_wire_select;
					end
				end
				SRP_DONE: begin
					if (link.sclk_fall && rw) begin
						// final fall: hold the line low until frame ends
						next_pins.sdio_out     = 1'b0;
						next_pins.ser_data_out = 1'b0;
					end
				end
				default: begin
					next_state = SRP_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state   <= SRP_WAIT;
			regs    <= {SRP_NUM_REGS{SRP_REG_RESET}};
			pins    <= '{sdio_out: 1'b0, sdio_oe_n: 1'b1,
				ser_data_out: 1'b0, sdo_oe_n: 1'b1};
			shift   <= 8'h00;
			tx      <= 8'h00;
			bit_cnt <= SRP_BIT_ZERO;
			left    <= SRP_CNT_ZERO;
			addr    <= 5'h00;
			rw      <= 1'b0;
		end else if (ce) begin
			state   <= next_state;
			regs    <= next_regs;
			pins    <= next_pins;
			shift   <= next_shift;
			tx      <= next_tx;
			bit_cnt <= next_bit_cnt;
			left    <= next_left;
			addr    <= next_addr;
			rw      <= next_rw;
		end
	end

	// outputs straight from flops
	assign sdio_out         = pins.sdio_out;
	assign sdio_oe_n        = pins.sdio_oe_n;
	assign ser_data_out     = pins.ser_data_out;
	assign sdo_oe_n         = pins.sdo_oe_n;
	assign cfg_regs         = regs;
	assign four_wire_select = regs[SRP_MODE_ADDR][SRP_FOUR_WIRE_B];

	// checks
	chk_one_driver: assert property (@(posedge clk) disable iff (rst)
		!(!sdio_oe_n && !sdo_oe_n)) else $error("both data pins driven");
	chk_three_pin_out: assert property (@(posedge clk) disable iff (rst)
		ce && !four_wire_select && link.sclk_fall && rw && state == SRP_DATA
		&& !link.frame_n |=> !sdio_oe_n && sdo_oe_n) else $error("three-pin read misrouted");
	chk_four_pin_out: assert property (@(posedge clk) disable iff (rst)
		ce && four_wire_select && link.sclk_fall && rw && state == SRP_DATA
		&& !link.frame_n |=> sdio_oe_n && !sdo_oe_n) else $error("four-pin read misrouted");
	chk_instr_quiet: assert property (@(posedge clk) disable iff (rst)
		state == SRP_INSTR |-> sdio_oe_n && sdo_oe_n) else $error("drive during instruction");
	chk_done_low: assert property (@(posedge clk) disable iff (rst)
		ce && state == SRP_DONE && link.sclk_fall && rw && !link.frame_n
		|=> !sdio_out && !ser_data_out) else $error("tail not low");
	chk_frame_release: assert property (@(posedge clk) disable iff (rst)
		ce && link.frame_n |=> state == SRP_WAIT && bit_cnt == SRP_BIT_ZERO
		&& sdio_oe_n && sdo_oe_n) else $error("abort not cleared");
	chk_write_lands: assert property (@(posedge clk) disable iff (rst)
		ce && state == SRP_DATA && !rw && link.sclk_rise && bit_cnt == SRP_LAST_BIT
		&& !link.frame_n && addr != SRP_RSVD_1E_ADDR |=> regs[$past(addr)] == $past(shifted))
		else $error("write not stored");
	chk_addr_down: assert property (@(posedge clk) disable iff (rst)
		ce && state == SRP_DATA && link.sclk_rise && bit_cnt == SRP_LAST_BIT
		&& left != SRP_CNT_ZERO && !link.frame_n
		|=> addr == $past(addr) - SRP_ADDR_ONE) else $error("address not decremented");
	chk_count_decode: assert property (@(posedge clk) disable iff (rst)
		ce && state == SRP_INSTR && link.sclk_rise && bit_cnt == SRP_LAST_BIT
		&& !link.frame_n |=> left == $past(shifted[SRP_CNT_HI:SRP_CNT_LO])
		&& rw == $past(shifted[SRP_RW_B])) else $error("instruction decode wrong");
	chk_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
		regs[SRP_RSVD_1E_ADDR] == SRP_REG_RESET) else $error("reserved slot written");

	cov_write_four: cover property (@(posedge clk) disable iff (rst)
		state == SRP_DATA && !rw && left == 2'h3);
	cov_read_three: cover property (@(posedge clk) disable iff (rst)
		state == SRP_DONE && rw && !sdio_oe_n);
	cov_read_four: cover property (@(posedge clk) disable iff (rst)
		state == SRP_DONE && rw && !sdo_oe_n);
	cov_abort: cover property (@(posedge clk) disable iff (rst)
		state == SRP_DATA && link.frame_n);

endmodule

// ==== testbench/srp_host_model.sv ====
// Purpose: host model acting as serial master of the port
// Assumes: sclk half period of four clk cycles, sclk idles low
// Notes:   a released data line shows the inverse of its last value
`timescale 1ns/10ps
module srp_host_model (
	// clock
	input  wire logic        clk,
	// device pins
	input  wire logic        sdio_out,
	input  wire logic        sdio_oe_n,
	input  wire logic        ser_data_out,
	input  wire logic        sdo_oe_n,
	input  wire logic        four_wire_select,
	output logic             sclk = 1'b0,
	output logic             frame_enable_n = 1'b1,
	output logic             sdio_in,
	// results seen by the host
	output logic [7:0]       got_byte = 8'h00,
	output logic             got_stb = 1'b0
);
	logic drv = 1'b0;
	logic drv_en = 1'b0;
	logic last = 1'b0;
	logic sdo_line;
	logic sdo_last = 1'b0;

	// resolved data line, nobody driving gives the inverse of the last level
	always_comb sdio_in = !sdio_oe_n ? sdio_out : (drv_en ? drv : ~last);

	// resolved out line, released it shows the inverse of its last level
	always_comb sdo_line = !sdo_oe_n ? ser_data_out : ~sdo_last;

	// memory of the line levels
	always @(posedge clk) last <= sdio_in;
	always @(posedge clk) sdo_last <= sdo_line;

	// hand one result to the bench
	task automatic send(input logic [7:0] v);
		got_byte <= v;
		got_stb  <= ~got_stb;
	endtask

	// one frame of nbits bits, instruction first, then data left aligned
	task automatic xfer(input logic [7:0] ins, input logic [31:0] dat, input int nbits);
		logic [39:0] sh;
		logic [7:0]  rb;
		int          i;
		sh = {ins, dat};
		rb = 8'h00;
		@(posedge clk);
		frame_enable_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (i = 0; i < nbits; i++) begin
			sclk   <= 1'b0;
			drv    <= sh[39 - i];
			drv_en <= !(ins[7] && i >= 8);
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (3) @(posedge clk);
			@(negedge clk);
			rb = {rb[6:0], four_wire_select ? sdo_line : sdio_in};
			if (ins[7] && i >= 8 && i % 8 == 7) send(rb);
			@(posedge clk);
		end
		sclk   <= 1'b0;
		drv_en <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		if (ins[7] && nbits == 8 * (ins[6:5] + 2))
			send({5'h00, sdio_oe_n, sdo_oe_n, four_wire_select ? sdo_line : sdio_in});
		@(posedge clk);
		frame_enable_n <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		if (ins[7] && nbits == 8 * (ins[6:5] + 2))
			send({5'h00, sdio_oe_n, sdo_oe_n, sdio_out | ser_data_out});
		repeat (2) @(posedge clk);
	endtask
endmodule

// ==== testbench/srp_port_bench.sv ====
// Purpose: self-checking bench of the serial register port
// Assumes: host model as master, sclk period 320 ns
// Notes:   driver queues expected results, monitor pops them
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module srp_port_bench;
	import srp_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         ce = 1'b0;
	logic         sclk, frame_enable_n, sdio_in, sdio_out, sdio_oe_n, ser_data_out, sdo_oe_n;
	logic         four_wire_select, got_stb;
	logic [7:0]   got_byte, e_v;
	srp_regs_type cfg_regs;
	logic [7:0]   model [32] = '{default: SRP_REG_RESET};
	logic [7:0]   exp_q [$];
	int           bad_count = 0;
	int           check_count = 0;
	int           seed = 76;

	// clock
	always #20 clk = ~clk;

	srp_port dut_u (.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .frame_enable_n(frame_enable_n),
		.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.ser_data_out(ser_data_out), .sdo_oe_n(sdo_oe_n), .cfg_regs(cfg_regs),
		.four_wire_select(four_wire_select));
	srp_host_model host_u (.clk(clk), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.ser_data_out(ser_data_out), .sdo_oe_n(sdo_oe_n), .four_wire_select(four_wire_select),
		.sclk(sclk), .frame_enable_n(frame_enable_n), .sdio_in(sdio_in),
		.got_byte(got_byte), .got_stb(got_stb));

	// write c+1 bytes downward from a, tracking the expected map
	task automatic wr(input logic [4:0] a, input logic [1:0] c, input logic [31:0] d);
		int k;
		for (k = 0; k <= c; k++)
			if (5'(a - k) != SRP_RSVD_1E_ADDR) model[5'(a - k)] = d[31 - 8 * k -: 8];
		host_u.xfer({1'b0, c, a}, d, 8 * (c + 2));
	endtask

	// read c+1 bytes, then the low tail and the release
	task automatic rd(input logic [4:0] a, input logic [1:0] c);
		int k;
		for (k = 0; k <= c; k++) exp_q.push_back(model[5'(a - k)]);
		exp_q.push_back(model[SRP_MODE_ADDR][SRP_FOUR_WIRE_B] ? 8'h04 : 8'h02);
		exp_q.push_back(8'h06);
		host_u.xfer({1'b1, c, a}, 32'h0, 8 * (c + 2));
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// monitor: each host result against the oldest note
	always @(got_stb) begin
		#1; // let both host results settle
		if (!rst) begin
			e_v = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
			`CHK("host result", e_v, got_byte)
		end
	end

	// watchdog
	initial begin
		#(40 * 40000);
		bad_count++;
		$display("Error watchdog expected finish seen hang");
		wrap_up;
	end

	// main sequence
	initial begin
		logic [31:0] d;
		int          c;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		ce  <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("reset map", {SRP_NUM_REGS{SRP_REG_RESET}}, cfg_regs)
		`CHK("reset enables", 2'b11, {sdio_oe_n, sdo_oe_n})
		$display("test reset done");
		for (c = 0; c < 4; c++) begin
			d = $random(seed);
			wr(5'(8 + 5 * c), 2'(c), d);
			rd(5'(8 + 5 * c), 2'(c));
		end
		d = $random(seed);
		wr(5'h01, 2'h3, d);
		rd(5'h01, 2'h3);
		$display("test counts and wrap done");
		host_u.xfer({3'h0, 5'h08}, 32'hFFFFFFFF, 13);
		rd(5'h08, 2'h0);
		$display("test abort done");
		// a whole write frame while the clock enable is low must leave no trace
		ce <= 1'b0;
		host_u.xfer({3'h0, 5'h08}, {~model[8], 24'h000000}, 16);
		ce <= 1'b1;
		`CHK("frozen register", model[8], cfg_regs[8])
		$display("test clock enable done");
		d = $random(seed);
		d[30] = 1'b1;
		wr(SRP_MODE_ADDR, 2'h0, d);
		`CHK("mode bit", 1'b1, four_wire_select)
		rd(5'h17, 2'h3);
		rd(SRP_MODE_ADDR, 2'h0);
		wr(SRP_MODE_ADDR, 2'h0, 32'h0);
		rd(SRP_MODE_ADDR, 2'h0);
		$display("test four-pin done");
		for (c = 0; c < 32; c++)
			`CHK("register", model[c], cfg_regs[c])
		`CHK("queue empty", 0, exp_q.size())
		$display("test map done");
		wrap_up;
	end
endmodule
